// [inc/astf_pkg.sv]
`default_nettype none
package astf_pkg;
    // Register map, byte addresses on the plain register port.
    localparam logic [7:0] ADR_TRIG   = 8'h00; // trigger_source_control
    localparam logic [7:0] ADR_MODE   = 8'h01; // Scan mode, wrap, clear option.
    localparam logic [7:0] ADR_START  = 8'h02; // sequence_start_control
    localparam logic [7:0] ADR_STUP   = 8'h03; // completion_status_upper
    localparam logic [7:0] ADR_STLO   = 8'h04; // Lower completion flags.
    localparam logic [7:0] ADR_STATE  = 8'h05; // Sequencer state.
    localparam logic [3:0] ADR_RES_HI = 4'h1;  // Results sit at 0x10 to 0x1f.

    // Field positions.
    localparam int TRG_KIND = 7;  // trigger_origin_kind
    localparam int MOD_SEVERAL_LINE_SCAN_MODE = 4;  // several_line_scan_mode
    localparam int MOD_FAST_FLAG_CLEAR = 5;  // fast_flag_clear
    localparam int MOD_ETRG = 6;  // External trigger enable.
    localparam int STA_SC   = 4;  // special_line_enable
    localparam int ST_BUSY  = 0;  // Sequence running.
    localparam int ST_RSVD  = 1;  // Last start used a reserved code.

    // Reset values.
    localparam logic [7:0]  TRIG_RST  = 8'h00;
    localparam logic [15:0] MODE_RST  = 16'h0000;
    localparam logic [7:0]  START_RST = 8'h00;

    // Special codes that name a real reference level.
    localparam logic [3:0] SPC_HIGH = 4'h4; // high_reference_level
    localparam logic [3:0] SPC_LOW  = 4'h5; // low_reference_level
    localparam logic [3:0] SPC_MID  = 4'h6; // Midpoint of the two.

    // Whether dedicated_trigger_inputs exist on this part.
    localparam logic DED_TRIG_PRESENT = 1'b1;

    // Sizes.
    localparam int NLINE = 16; // sensed_input_lines
    localparam int NDED  = 4;  // dedicated_trigger_inputs
    localparam int NPOS  = 16; // Positions in a sequence.
    localparam int RESW  = 10; // Result width.

    // Request handed to the converter front end.
    typedef struct packed {
        logic       special; // Code selects a reference level.
        logic [3:0] code;    // Input line or special code.
    } astf_conv_t;

    // Sequencer states.
    typedef enum logic [1:0] {
        SQ_IDLE,
        SQ_ISSUE,
        SQ_WAIT
    } astf_state_t;
endpackage : astf_pkg
`default_nettype wire

// [src/astf_top.sv]
// The register offsets and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module astf_top (
    input  wire logic                  clk,          // Bus clock, 50 MHz.
    input  wire logic                  rst_n,        // Synchronous reset, low.
    input  wire logic [7:0]            addr,         // Register address.
    input  wire logic [15:0]           wdata,        // Write data.
    input  wire logic                  wr,           // Write strobe.
    input  wire logic                  rd,           // Read strobe.
    output logic      [15:0]           rdata,        // Read data, cycle after rd.
    input  wire logic [15:0]           sensed_input_lines, // Line levels.
    input  wire logic [3:0]            dedicated_trigger_inputs, // Trigger pins.
    output logic                       conv_start,   // Start one conversion.
    output astf_pkg::astf_conv_t       conv_sel,     // What to convert.
    output logic                       conv_abort,   // Drop conversion in flight.
    input  wire logic                  conv_done,    // Conversion finished.
    input  wire logic [9:0]            conv_result   // Result with conv_done.
);
    // Register contents.
    logic [7:0]             trig_r;   // trigger_source_control
    logic [15:0]            mode_r;   // Wrap, mode and option bits.
    logic [7:0]             start_r;  // Last sequence_start_control value.
    logic [15:0]            flags_r;  // conversion_done_flag per position.
    logic [15:0]            arm_r;    // Status read seen, slow clear armed.
    logic [9:0]             res_r [16]; // result_register array.
    logic                   rsvd_r;   // Last start used a reserved code.
    logic [15:0]            rdata_r;  // Registered read data.

    // Sequencer.
    astf_pkg::astf_state_t  st_r;     // Sequencer state.
    logic [3:0]             pos_r;    // Position within the sequence.
    logic [3:0]             ch_r;     // Current input line.
    astf_pkg::astf_conv_t   sel_r;    // Request held for the front end.

    // Pin synchronisers and trigger edge.
    logic [19:0]            s1_r;     // First stage, read only by s2_r.
    logic [19:0]            s2_r;     // Second stage.
    logic [19:0]            s3_r;     // Third stage.
    logic [19:0]            flt_r;    // Value once stages two and three agree.
    logic                   trg_prev_r; // Trigger level last cycle.

    // Decoded bus strobes.
    logic                   wr_trig;  // Write to trigger control.
    logic                   wr_start; // Write to start control.
    logic                   rd_stup;  // Read of upper status.
    logic                   rd_stlo;  // Read of lower status.
    logic                   res_rd;   // Read of a result register.
    logic [3:0]             idx_w;    // Result register index.
    logic                   done_w;   // Accepted conversion end.
    logic                   trg_src;  // Selected trigger level.
    logic                   trg_go;   // Trigger rising edge while idle.
    logic                   last_w;   // Current position is the last.
    logic                   code_ok;  // Special code is not reserved.
    logic [15:0]            set_w;    // Flag set this cycle.
    logic [3:0]             wrap_w;   // Wrap field.

    // Bus decode is purely combinational on the strobes.
    assign wr_trig  = wr && addr == astf_pkg::ADR_TRIG;
    assign wr_start = wr && addr == astf_pkg::ADR_START;
    assign rd_stup  = rd && addr == astf_pkg::ADR_STUP;
    assign rd_stlo  = rd && addr == astf_pkg::ADR_STLO;
    assign res_rd   = rd && addr[7:4] == astf_pkg::ADR_RES_HI;
    assign idx_w    = addr[3:0];
    // A conversion end that meets a trigger control write is dropped with the sequence.
    assign done_w   = st_r == astf_pkg::SQ_WAIT && conv_done && !wr_trig;
    assign last_w   = pos_r == mode_r[11:8];
    assign wrap_w   = mode_r[3:0];

    // The sequence length field holds the count minus one.
    // A special start must use one of the three reference codes.
    assign code_ok = wdata[3:0] == astf_pkg::SPC_HIGH ||
                     wdata[3:0] == astf_pkg::SPC_LOW  ||
                     wdata[3:0] == astf_pkg::SPC_MID;

    // Pick the trigger level; without dedicated inputs the stored
    // origin bit is ignored and an analog line stays the source.
    always_comb begin
        if (trig_r[astf_pkg::TRG_KIND] && astf_pkg::DED_TRIG_PRESENT) begin
            trg_src = flt_r[astf_pkg::NLINE + trig_r[1:0]];
        end else begin
            trg_src = flt_r[trig_r[3:0]];
        end
    end
    assign trg_go = mode_r[astf_pkg::MOD_ETRG] && trg_src && !trg_prev_r &&
                    st_r == astf_pkg::SQ_IDLE;

    // Handshake outputs are combinational: conv_start from the state, conv_abort from a trigger control write outside idle.
    assign conv_start = st_r == astf_pkg::SQ_ISSUE;
    assign conv_abort = wr_trig && st_r != astf_pkg::SQ_IDLE;
    assign conv_sel   = sel_r;
    assign rdata      = rdata_r;

    // Three stages on the pins; a change is taken only when the
    // second and third stage agree, which rejects single-cycle glitches.
    // Only the second stage reads the first, whose value may still be settling.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s1_r       <= 20'h00000;
            s2_r       <= 20'h00000;
            s3_r       <= 20'h00000;
            flt_r      <= 20'h00000;
            trg_prev_r <= 1'b0;
        end else begin
            s1_r       <= {dedicated_trigger_inputs, sensed_input_lines};
            s2_r       <= s1_r;
            s3_r       <= s2_r;
            flt_r      <= (s2_r & s3_r) | (flt_r & (s2_r ^ s3_r));
            trg_prev_r <= trg_src;
        end
    end

    // Software-written control registers.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            trig_r  <= astf_pkg::TRIG_RST;
            mode_r  <= astf_pkg::MODE_RST;
            start_r <= astf_pkg::START_RST;
        end else begin
            if (wr_trig) begin
                trig_r <= wdata[7:0];
            end
            if (wr && addr == astf_pkg::ADR_MODE) begin
                mode_r <= wdata;
            end
            if (wr_start) begin
                start_r <= wdata[7:0];
            end
        end
    end

    // Sequencer. A trigger control write drops everything and waits
    // for a fresh start; a reserved special code refuses the start.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_r   <= astf_pkg::SQ_IDLE;
            pos_r  <= 4'h0;
            ch_r   <= 4'h0;
            sel_r  <= '0;
            rsvd_r <= 1'b0;
        end else if (wr_trig) begin
            st_r <= astf_pkg::SQ_IDLE;
        end else if (wr_start) begin
            // Start write restarts even a running sequence.
            pos_r  <= 4'h0;
            ch_r   <= wdata[3:0];
            rsvd_r <= wdata[astf_pkg::STA_SC] && !code_ok;
            sel_r  <= '{special: wdata[astf_pkg::STA_SC], code: wdata[3:0]};
            if (wdata[astf_pkg::STA_SC] && !code_ok) begin
                st_r <= astf_pkg::SQ_IDLE;
            end else begin
                st_r <= astf_pkg::SQ_ISSUE;
            end
        end else begin
            case (st_r)
                astf_pkg::SQ_IDLE: begin
                    // An external edge replays start_r unless the last start write was refused.
                    if (trg_go && !rsvd_r) begin
                        pos_r <= 4'h0;
                        ch_r  <= start_r[3:0];
                        sel_r <= '{special: start_r[astf_pkg::STA_SC],
                                   code: start_r[3:0]};
                        st_r  <= astf_pkg::SQ_ISSUE;
                    end
                end
                astf_pkg::SQ_ISSUE: begin
                    // The request stands for this one cycle only.
                    st_r <= astf_pkg::SQ_WAIT;
                end
                astf_pkg::SQ_WAIT: begin
                    if (conv_done) begin
                        if (last_w) begin
                            st_r <= astf_pkg::SQ_IDLE;
                        end else begin
                            pos_r <= pos_r + 4'h1;
                            st_r  <= astf_pkg::SQ_ISSUE;
                            if (mode_r[astf_pkg::MOD_SEVERAL_LINE_SCAN_MODE] && !sel_r.special) begin
                                // Wrap zero is reserved and simply runs on.
                                if (ch_r == wrap_w && wrap_w != 4'h0) begin
                                    ch_r       <= 4'h0;
                                    sel_r.code <= 4'h0;
                                end else begin
                                    ch_r       <= ch_r + 4'h1;
                                    sel_r.code <= ch_r + 4'h1;
                                end
                            end
                        end
                    end
                end
                default: begin
                    st_r <= astf_pkg::SQ_IDLE;
                end
            endcase
        end
    end

    // Results are stored at the position that produced them.
    always_ff @(posedge clk) begin
        if (done_w) begin
            res_r[pos_r] <= conv_result;
        end
    end

    // One flag and one arm bit per position. Start clears win over a
    // set; a set wins over any read clear in the same cycle.
    // A status read arms every position of its half, set or not, except a position whose flag is set in that same cycle.
    genvar gi;
    generate
        for (gi = 0; gi < astf_pkg::NPOS; gi++) begin : g_flag
            assign set_w[gi] = done_w && pos_r == gi;
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    flags_r[gi] <= 1'b0;
                    arm_r[gi]   <= 1'b0;
                end else if (wr_start) begin
                    flags_r[gi] <= 1'b0;
                    arm_r[gi]   <= 1'b0;
                end else if (set_w[gi]) begin
                    flags_r[gi] <= 1'b1;
                end else if (res_rd && idx_w == gi) begin
                    arm_r[gi] <= 1'b0;
                    if (mode_r[astf_pkg::MOD_FAST_FLAG_CLEAR] || arm_r[gi]) begin
                        flags_r[gi] <= 1'b0;
                    end
                end else if ((gi >= 8 && rd_stup) || (gi < 8 && rd_stlo)) begin
                    arm_r[gi] <= 1'b1;
                end
            end
        end
    endgenerate

    // Read data stands in the cycle after the strobe only; writes to
    // the status registers fall through and change nothing.
    always_ff @(posedge clk) begin
        if (!rst_n || !rd) begin
            rdata_r <= 16'h0000;
        end else if (res_rd) begin
            rdata_r <= {6'h00, res_r[idx_w]};
        end else begin
            case (addr)
                astf_pkg::ADR_TRIG:  rdata_r <= {8'h00, trig_r};
                astf_pkg::ADR_MODE:  rdata_r <= mode_r;
                astf_pkg::ADR_START: rdata_r <= {8'h00, start_r};
                astf_pkg::ADR_STUP:  rdata_r <= {8'h00, flags_r[15:8]};
                astf_pkg::ADR_STLO:  rdata_r <= {8'h00, flags_r[7:0]};
                astf_pkg::ADR_STATE: rdata_r <= {8'h00, pos_r, 2'h0, rsvd_r,
                                                 st_r != astf_pkg::SQ_IDLE};
                default:             rdata_r <= 16'h0000;
            endcase
        end
    end

    // Checks on the block's own behaviour.
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_wrap_to_first: assert property (
        st_r == astf_pkg::SQ_WAIT && conv_done && !wr && !last_w &&
        mode_r[astf_pkg::MOD_SEVERAL_LINE_SCAN_MODE] && !sel_r.special &&
        wrap_w != 4'h0 && ch_r == wrap_w
        // The next request goes out in the cycle right after the conversion end.
        |=> ch_r == 4'h0 && conv_start && conv_sel.code == 4'h0)
        else $error("scan did not wrap to the first line");

    a_trig_abort: assert property (
        wr_trig |=> st_r == astf_pkg::SQ_IDLE && !conv_start)
        else $error("trigger control write did not abort");

    a_abort_no_restart: assert property (
        // A trigger edge right after the abort may start legally, so it is excluded.
        wr_trig ##1 (!wr && !trg_go) |=> !conv_start)
        else $error("trigger control write started a sequence");

    a_trig_origin: assert property (
        !trig_r[astf_pkg::TRG_KIND] || !astf_pkg::DED_TRIG_PRESENT
        |-> trg_src == flt_r[trig_r[3:0]])
        else $error("trigger not taken from an analog line");

    a_trig_ded_pick: assert property (
        trig_r[astf_pkg::TRG_KIND] && astf_pkg::DED_TRIG_PRESENT
        |-> trg_src == flt_r[astf_pkg::NLINE + trig_r[1:0]])
        else $error("wrong dedicated trigger picked");

    a_special_code: assert property (
        conv_start && conv_sel.special
        |-> conv_sel.code inside {4'h4, 4'h5, 4'h6})
        else $error("reserved special code issued");

    a_flag_set: assert property (
        done_w && !wr_start |=> flags_r[$past(pos_r)])
        else $error("completion flag not set");

    a_start_clear: assert property (
        wr_start |=> flags_r == 16'h0000)
        else $error("start write left a flag set");

    a_slow_hold: assert property (
        res_rd && !mode_r[astf_pkg::MOD_FAST_FLAG_CLEAR] && !arm_r[idx_w] &&
        !done_w && !wr_start |=> $stable(flags_r))
        else $error("flag cleared without prior status read");

    a_fast_clear: assert property (
        res_rd && mode_r[astf_pkg::MOD_FAST_FLAG_CLEAR] && !done_w && !wr_start
        |=> !flags_r[$past(idx_w)])
        else $error("fast clear did not clear flag");

    a_set_beats_read: assert property (
        res_rd && done_w && idx_w == pos_r && !wr_start
        |=> flags_r[$past(idx_w)])
        else $error("read clear beat a set");

    a_status_write: assert property (
        wr && addr == astf_pkg::ADR_STUP && !done_w && !res_rd
        |=> $stable(flags_r))
        else $error("status write changed flags");

    a_status_read: assert property (
        rd_stup |=> rdata[7:0] == $past(flags_r[15:8]) && rdata[15:8] == 8'h00)
        else $error("upper status read wrong");

    // Scenarios that the bench is expected to reach.
    c_full_seq: cover property (
        st_r == astf_pkg::SQ_WAIT && conv_done && last_w && pos_r == 4'hf);
    c_wrap: cover property (
        st_r == astf_pkg::SQ_WAIT && conv_done && ch_r == wrap_w &&
        mode_r[astf_pkg::MOD_SEVERAL_LINE_SCAN_MODE] && wrap_w != 4'h0 && !last_w);
    c_slow_clear: cover property (
        rd_stup ##[1:4] (res_rd && idx_w[3] && flags_r[idx_w]));
    c_ext_trigger: cover property (trg_go ##1 conv_start);
    // A result read colliding with the set of its own flag.
    c_set_read: cover property (res_rd && done_w && idx_w == pos_r);
endmodule : astf_top
`default_nettype wire

// [testbench/adc_sequence_trigger_flags_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module adc_sequence_trigger_flags_tb;
    logic                 clk = 1'b0;     // Bus clock, 50 MHz.
    logic                 rst_n = 1'b0;   // Synchronous reset, low.
    logic [7:0]           addr = 8'h00;   // Register address.
    logic [15:0]          wdata = 16'h0000; // Write data.
    logic                 wr = 1'b0;      // Write strobe.
    logic                 rd = 1'b0;      // Read strobe.
    logic [15:0]          rdata;          // Read data.
    logic [15:0]          sensed_input_lines = 16'h0000; // Line levels.
    logic [3:0]           dedicated_trigger_inputs = 4'h0; // Trigger pins.
    logic                 conv_start;     // Front end request.
    astf_pkg::astf_conv_t conv_sel;       // What to convert.
    logic                 conv_abort;     // Abort pulse.
    logic                 conv_done = 1'b0; // Conversion finished.
    logic [9:0]           conv_result = 10'h000; // Result with conv_done.
    int                   num_errors = 0; // Mismatches seen.
    int                   tests_run = 0;  // Comparisons made.
    int                   seed = 39614;   // Fixed seed keeps runs repeatable.
    int                   pos = 0;        // Position of the next answered conversion.
    int                   cyc = 0;        // Cycles since time zero.
    int                   nstart = 0;     // Conversion requests seen.
    int                   k;              // Loop counter.
    bit                   auto_on = 1'b1; // Responder answers requests.
    bit                   fast = 1'b0;    // Model copy of the clear option.
    bit                   abort_seen;     // Abort level during the last write.
    logic [15:0]          flags = 16'h0;  // Model completion flags.
    logic [15:0]          armed = 16'h0;  // Model arm bits of the slow clear.
    logic [9:0]           res [16];       // Model result registers.
    logic [4:0]           exp_q [$];      // Expected conversion selections.

    astf_top uut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .sensed_input_lines(sensed_input_lines),
        .dedicated_trigger_inputs(dedicated_trigger_inputs), .conv_start(conv_start),
        .conv_sel(conv_sel), .conv_abort(conv_abort), .conv_done(conv_done),
        .conv_result(conv_result));

    // Free running clock.
    always #10 clk = ~clk;

    // A hang is cut short so the run always reaches the verdict.
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            $display("MISMATCH %0t timeout %h %h", $time, cyc, 20000);
            close_out();
        end
    end

    // Front end stand-in: answers each request one cycle later with a random result.
    always @(posedge clk) begin
        if (conv_start === 1'b1) nstart++;
        if (auto_on) begin
            conv_done <= 1'b0;
            if (conv_start === 1'b1) begin
                // A request nobody asked for is checked against a zero selection.
                if (exp_q.size() > 0) chk_sel(conv_sel, exp_q.pop_front());
                else chk_sel(conv_sel, 5'h00);
                res[pos % 16] = 10'($random(seed));
                conv_result <= res[pos % 16];
                conv_done <= 1'b1;
                flags[pos % 16] = 1'b1;
                pos++;
            end
        end
    end

    task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk_reg

    task automatic chk_sel(input logic [4:0] got, input logic [4:0] exp);
        tests_run++;
        if (got !== exp || exp_q.size() > 16) begin
            num_errors++;
            $display("MISMATCH %0t sel %h exp %h", $time, got, exp);
        end
    endtask : chk_sel

    // One write cycle; the abort level is captured mid-cycle while wr is high.
    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(negedge clk);
        abort_seen = conv_abort;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    // One read cycle; rdata is looked at only in the cycle after the strobe.
    task automatic rd_reg(input logic [7:0] a, input logic [15:0] e, input logic [15:0] m);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk_reg(rdata & m, e & m);
    endtask : rd_reg

    // Status reads arm the set flags of their half for the slow clear.
    task automatic rd_flags(input bit hi);
        rd_reg(hi ? astf_pkg::ADR_STUP : astf_pkg::ADR_STLO,
               {8'h00, hi ? flags[15:8] : flags[7:0]}, 16'hffff);
        armed = armed | (flags & (hi ? 16'hff00 : 16'h00ff));
    endtask : rd_flags

    task automatic rd_res(input int i);
        rd_reg({astf_pkg::ADR_RES_HI, 4'(i)}, {6'h00, res[i]}, 16'hffff);
        if (fast || armed[i]) flags[i] = 1'b0;
        armed[i] = 1'b0;
    endtask : rd_res

    task automatic set_mode(input int wrap, input bit several_line_scan_mode, input bit ff, input bit ext,
                            input int len);
        fast = ff;
        wr_reg(astf_pkg::ADR_MODE, {4'h0, 4'(len), 1'b0, ext, ff, several_line_scan_mode, 4'(wrap)});
    endtask : set_mode

    // Predicts the scan order, starts the sequence and waits for it to finish.
    task automatic run_seq(input logic [4:0] sv, input int n, input int wrap, input bit several_line_scan_mode);
        logic [3:0] ch;
        int         w;
        ch = sv[3:0];
        for (w = 0; w < n; w++) begin
            exp_q.push_back({sv[4], ch});
            // Wrap only counts in several-line mode on ordinary lines.
            if (several_line_scan_mode && !sv[4]) ch = (ch == 4'(wrap)) ? 4'h0 : ch + 4'h1;
        end
        pos   = 0;
        flags = 16'h0;
        armed = 16'h0;
        wr_reg(astf_pkg::ADR_START, {11'h000, sv});
        w = 0;
        while ((pos < n || exp_q.size() > 0) && w < 200) begin
            @(posedge clk);
            w++;
        end
        repeat (4) @(posedge clk);
    endtask : run_seq

    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : close_out

    // Main sequence.
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        // Reset values, and two unmapped addresses that must read as zero.
        for (k = 0; k < 8; k++) rd_reg(8'(k), 16'h0000, k == 5 ? 16'h0003 : 16'hffff);
        $display("reset values done");
        k = $random(seed);
        wr_reg(astf_pkg::ADR_TRIG, {8'h00, k[7], 3'h0, k[3:0]});
        rd_reg(astf_pkg::ADR_TRIG, {8'h00, k[7], 3'h0, k[3:0]}, 16'h008f);
        $display("trigger register done");
        set_mode(5, 1'b1, 1'b0, 1'b0, 15);
        run_seq(5'h00, 16, 5, 1'b1);
        rd_flags(1'b1);
        rd_flags(1'b0);
        wr_reg(astf_pkg::ADR_STUP, 16'h0000);
        rd_flags(1'b1);
        for (k = 8; k < 16; k++) rd_res(k);
        rd_flags(1'b1);
        $display("wrap and slow clear done");
        set_mode(0, 1'b0, 1'b0, 1'b0, 3);
        run_seq(5'h03, 4, 0, 1'b0);
        rd_res(0);
        rd_flags(1'b0);
        rd_res(0);
        rd_flags(1'b0);
        $display("unarmed read done");
        set_mode(1, 1'b1, 1'b1, 1'b0, 3);
        run_seq(5'h00, 4, 1, 1'b1);
        rd_res(2);
        rd_flags(1'b0);
        $display("fast clear done");
        // A start write landing with a conversion end must leave every flag clear.
        auto_on = 1'b0;
        run_seq(5'h01, 0, 0, 1'b0);
        k = 0;
        while (conv_start !== 1'b1 && k < 50) begin
            @(negedge clk);
            k++;
        end
        @(posedge clk);
        conv_done <= 1'b1;
        addr      <= astf_pkg::ADR_START;
        wdata     <= 16'h0001;
        wr        <= 1'b1;
        @(posedge clk);
        conv_done <= 1'b0;
        wr        <= 1'b0;
        rd_flags(1'b0);
        // A fast-clear result read landing with the set of that flag loses to it.
        @(posedge clk);
        conv_done <= 1'b1;
        addr      <= {astf_pkg::ADR_RES_HI, 4'h0};
        rd        <= 1'b1;
        @(posedge clk);
        conv_done <= 1'b0;
        rd        <= 1'b0;
        flags     = 16'h0001;
        rd_flags(1'b0);
        $display("start beats set done");
        k = nstart;
        wr_reg(astf_pkg::ADR_TRIG, 16'h0000);
        chk_reg({15'h0000, abort_seen}, 16'h0001);
        repeat (20) @(posedge clk);
        chk_reg(16'(nstart - k), 16'h0000);
        rd_reg(astf_pkg::ADR_STATE, 16'h0000, 16'h0001);
        auto_on = 1'b1;
        $display("abort done");
        set_mode(0, 1'b0, 1'b0, 1'b0, 0);
        for (k = 0; k < 16; k++) begin
            run_seq({1'b1, 4'(k)}, (k >= 4 && k <= 6) ? 1 : 0, 0, 1'b0);
            rd_reg(astf_pkg::ADR_STATE, (k >= 4 && k <= 6) ? 16'h0 : 16'h2, 16'h3);
        end
        $display("special codes done");
        run_seq(5'h07, 1, 0, 1'b0);
        set_mode(0, 1'b0, 1'b0, 1'b1, 0);
        for (k = 0; k < 2; k++) begin
            wr_reg(astf_pkg::ADR_TRIG, {8'h00, k[0], 3'h0, k[0] ? 4'h2 : 4'h9});
            pos = 0;
            // A pin that is not picked must not start anything.
            if (k == 1) dedicated_trigger_inputs <= 4'h8;
            else sensed_input_lines <= 16'h0100;
            repeat (10) @(posedge clk);
            exp_q.push_back(5'h07);
            if (k == 1) dedicated_trigger_inputs <= 4'hc;
            else sensed_input_lines <= 16'h0300;
            repeat (20) @(posedge clk);
            chk_reg(16'(pos), 16'h0001);
            sensed_input_lines       <= 16'h0000;
            dedicated_trigger_inputs <= 4'h0;
            repeat (10) @(posedge clk);
        end
        $display("external trigger done");
        close_out();
    end
endmodule : adc_sequence_trigger_flags_tb
`default_nettype wire
